// ---- inc/crc_pkg.sv ----
package crc_pkg;
   localparam int CRC_NUM_CNT = 2;
   localparam int CRC_NUM_RNG = 32;
   localparam int CRC_DW = 32;
   localparam int CRC_AW = 12;
   // range entry region: counter select, entry index, word within entry
   localparam int CRC_CFG_BIT = 10;
   localparam int CRC_CTR_BIT = 9;
   localparam int CRC_ENT_HI = 8;
   localparam int CRC_ENT_LO = 4;
   localparam int CRC_WRD_HI = 3;
   localparam int CRC_WRD_LO = 2;
   localparam logic [1:0] CRC_WRD_LOWER = 2'h0;
   localparam logic [1:0] CRC_WRD_UPPER = 2'h1;
   localparam logic [1:0] CRC_WRD_PAT = 2'h2;
   // control and status registers
   localparam logic [11:0] CRC_OFF_OUT_CTL = 12'h400;
   localparam logic [11:0] CRC_OFF_CNT_TYPE = 12'h404;
   localparam logic [11:0] CRC_OFF_EN1 = 12'h408;
   localparam logic [11:0] CRC_OFF_EN2 = 12'h40c;
   localparam logic [11:0] CRC_OFF_ACT1 = 12'h410;
   localparam logic [11:0] CRC_OFF_ACT2 = 12'h414;
   localparam logic [11:0] CRC_OFF_STATUS = 12'h418;
   localparam logic [11:0] CRC_OFF_UNIT_PAT = 12'h41c;
   // output_control_config fields
   localparam int CRC_MODE_LO = 0;
   localparam int CRC_SEL_LO = 8;
   localparam int CRC_CTL_W = 16;
   localparam logic [7:0] CRC_MODE_RANGE = 8'h00;
   localparam logic [7:0] CRC_MODE_CMP = 8'h01;
   localparam logic [7:0] CRC_SEL_AND = 8'h01;
   localparam int CRC_STAT_PAUSE_LO = 8;
   // comparison pause after a limit hit
   localparam int CRC_CLK_PERIOD_NS = 50;
   localparam int CRC_PAUSE_NS = 1500000;
   localparam int CRC_PAUSE_CYCLES = CRC_PAUSE_NS / CRC_CLK_PERIOD_NS;
   localparam int CRC_PCNT_W = 16;
   typedef enum logic {CMP_RUN = 1'b0, CMP_HOLD = 1'b1} crc_pause_t;
endpackage : crc_pkg

// ---- inc/crc_cmp_if.sv ----
`timescale 1ns/1ps
interface crc_cmp_if;
   logic [31:0] value;
   logic circular;
   logic [31:0][31:0] lower;
   logic [31:0][31:0] upper;
   logic [31:0] in_range;
   logic [31:0] at_limit;
   logic [31:0] bad_order;
   modport eval (input value, circular, lower, upper, output in_range, at_limit, bad_order);
   modport core (output value, circular, lower, upper, input in_range, at_limit, bad_order);
endinterface : crc_cmp_if

// ---- rtl/crc_range_eval.sv ----
`timescale 1ns/1ps
module crc_range_eval
(
   // one counter's ranges
   crc_cmp_if.eval cmp
);
   import crc_pkg::*;
   genvar i;
   generate
      for (i = 0; i < CRC_NUM_RNG; i++)
      begin : g_rng
         logic [31:0] lo;
         logic [31:0] hi;
         logic [31:0] v;
         logic circ_in;
         logic lin_in;
         assign lo = cmp.lower[i];
         assign hi = cmp.upper[i];
         assign v = cmp.value;
         assign circ_in = (hi >= lo) ? (v >= lo && v <= hi) : (v >= lo || v <= hi);
         assign lin_in = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
         // circular counters use the wrapping unsigned test, linear counters the signed one
         assign cmp.in_range[i] = cmp.circular ? circ_in : lin_in;
         assign cmp.at_limit[i] = (v == lo) || (v == hi);
         // equal limits are a legal single value
         assign cmp.bad_order[i] = $signed(hi) < $signed(lo);
      end
   endgenerate
endmodule : crc_range_eval

// ---- rtl/crc_top.sv ----
// Operation
// - range evaluation works for circular and linear counters alike
// - each counter holds 32 ranges of lower, upper and pattern words
// - circular limits compare unsigned, linear limits compare signed
// - linear counter flags a configuration error for badly ordered limits
// - circular counter accepts upper below lower without error
// - equal lower and upper limits form a legal single-value range
// - pattern bit 0 and 1 drive the digital outputs, rest internal
// - an output turns on only where the active range pattern bit is 1
// - active ranges of one counter OR their patterns together
// - range is met when lower <= value <= upper, both inclusive
// - each counter shows a 32-bit word of active ranges
// - each range active state is also readable as a single bit
// - hitting a range limit pauses that counter's comparison for 1.5 ms
// - a pause on one counter leaves the other counter comparing
// - during the pause nothing new turns on; resumes after 1.5 ms
// - optional boundary hysteresis against encoder jitter; not built here, limits act without a dead band
// - mode field bits 0 to 7 select range or comparison operation; here any mode other than range only forces all outputs off
// - unit pattern is OR of counters, or AND when selected
// - each range has an enable, off at reset; disabled ranges ignored
// - counters without ranges skip the AND; none at all gives all off
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module crc_top
#(
   parameter int PAUSE_CYCLES = crc_pkg::CRC_PAUSE_CYCLES
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [crc_pkg::CRC_AW-1:0] paddr,
   input wire logic [crc_pkg::CRC_DW-1:0] pwdata,
   output logic [crc_pkg::CRC_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // counter values from the counting core
   input wire logic [crc_pkg::CRC_DW-1:0] first_counter_value,
   input wire logic [crc_pkg::CRC_DW-1:0] second_counter_value,
   // outputs and status
   output logic first_digital_output,
   output logic second_digital_output,
   output logic [crc_pkg::CRC_DW-1:0] unit_output_pattern,
   output logic [crc_pkg::CRC_NUM_RNG-1:0] first_counter_active_ranges,
   output logic [crc_pkg::CRC_NUM_RNG-1:0] second_counter_active_ranges,
   output logic [crc_pkg::CRC_NUM_CNT-1:0] config_error
);
   import crc_pkg::*;

   typedef struct packed {
      logic [1:0][31:0][31:0] low;
      logic [1:0][31:0][31:0] up;
      logic [1:0][31:0][31:0] pat;
      logic [CRC_CTL_W-1:0] ctl;
      logic [1:0] circ;
      logic [1:0][31:0] en;
      logic [1:0][31:0] act;
      logic [1:0][31:0] cpat;
      logic [1:0][31:0] prev;
      crc_pause_t [1:0] pst;
      logic [1:0][CRC_PCNT_W-1:0] pcnt;
      logic [1:0] err;
      logic [31:0] unit;
      logic dig0;
      logic dig1;
      logic [31:0] rdata;
      logic rdy;
      logic slverr;
   } crc_state_t;

   localparam logic [CRC_PCNT_W-1:0] PAUSE_LAST = CRC_PCNT_W'(PAUSE_CYCLES - 1);

   crc_state_t st_reg;
   crc_state_t st_next;
   logic [1:0][31:0] in_rng;
   logic [1:0][31:0] at_lim;
   logic [1:0][31:0] bad_ord;
   logic [1:0][31:0] cnt_val;

   assign cnt_val[0] = first_counter_value;
   assign cnt_val[1] = second_counter_value;

   genvar g;
   generate
      for (g = 0; g < CRC_NUM_CNT; g++)
      begin : g_cnt
         crc_cmp_if cmp_if ();
         assign cmp_if.value = cnt_val[g];
         assign cmp_if.circular = st_reg.circ[g];
         assign cmp_if.lower = st_reg.low[g];
         assign cmp_if.upper = st_reg.up[g];
         assign in_rng[g] = cmp_if.in_range;
         assign at_lim[g] = cmp_if.at_limit;
         assign bad_ord[g] = cmp_if.bad_order;
         crc_range_eval u_eval (.cmp(cmp_if.eval));
      end
   endgenerate

   always_comb
   begin
      logic setup;
      logic access;
      logic ctr;
      logic [4:0] ent;
      logic [1:0] wrd;
      logic [31:0] orv;
      logic [31:0] live;
      logic [7:0] mode;
      logic [7:0] sel;
      setup = 1'b0;
      access = 1'b0;
      ctr = 1'b0;
      ent = 5'h00;
      wrd = 2'h0;
      orv = 32'h0;
      live = 32'h0;
      mode = 8'h00;
      sel = 8'h00;
      st_next = st_reg;
      setup = psel && !penable;
      access = psel && penable && st_reg.rdy;
      ctr = paddr[CRC_CTR_BIT];
      ent = paddr[CRC_ENT_HI:CRC_ENT_LO];
      wrd = paddr[CRC_WRD_HI:CRC_WRD_LO];

      // ready registered in the setup phase lets read data come from a flop with no wait state
      st_next.rdy = setup;
      if (setup)
      begin
         st_next.rdata = 32'h0;
         st_next.slverr = 1'b0;
         if (!paddr[CRC_CFG_BIT])
         begin
            case (wrd)
               CRC_WRD_LOWER: st_next.rdata = st_reg.low[ctr][ent];
               CRC_WRD_UPPER: st_next.rdata = st_reg.up[ctr][ent];
               CRC_WRD_PAT: st_next.rdata = st_reg.pat[ctr][ent];
               default: st_next.slverr = 1'b1;
            endcase
         end
         else
         begin
            case (paddr)
               CRC_OFF_OUT_CTL: st_next.rdata = 32'(st_reg.ctl);
               CRC_OFF_CNT_TYPE: st_next.rdata = 32'(st_reg.circ);
               CRC_OFF_EN1: st_next.rdata = st_reg.en[0];
               CRC_OFF_EN2: st_next.rdata = st_reg.en[1];
               CRC_OFF_ACT1: st_next.rdata = st_reg.act[0];
               CRC_OFF_ACT2: st_next.rdata = st_reg.act[1];
               CRC_OFF_STATUS:
               begin
                  st_next.rdata[1:0] = st_reg.err;
                  st_next.rdata[CRC_STAT_PAUSE_LO +: 2] = st_reg.pst;
               end
               CRC_OFF_UNIT_PAT: st_next.rdata = st_reg.unit;
               default: st_next.slverr = 1'b1;
            endcase
         end
      end
      else if (access)
      begin
         st_next.slverr = 1'b0;
         st_next.rdata = 32'h0;
      end

      if (access && pwrite && !st_reg.slverr)
      begin
         if (!paddr[CRC_CFG_BIT])
         begin
            case (wrd)
               CRC_WRD_LOWER: st_next.low[ctr][ent] = pwdata;
               CRC_WRD_UPPER: st_next.up[ctr][ent] = pwdata;
               CRC_WRD_PAT: st_next.pat[ctr][ent] = pwdata;
               default: st_next.low = st_reg.low;
            endcase
         end
         else
         begin
            case (paddr)
               CRC_OFF_OUT_CTL: st_next.ctl = pwdata[CRC_CTL_W-1:0];
               CRC_OFF_CNT_TYPE: st_next.circ = pwdata[1:0];
               CRC_OFF_EN1: st_next.en[0] = pwdata;
               CRC_OFF_EN2: st_next.en[1] = pwdata;
               default: st_next.ctl = st_reg.ctl;
            endcase
         end
      end

      for (int c = 0; c < CRC_NUM_CNT; c++)
      begin
         // disabled ranges never count as active
         live = in_rng[c] & st_reg.en[c];
         orv = 32'h0;
         for (int i = 0; i < CRC_NUM_RNG; i++)
         begin
            if (live[i])
            begin
               orv = orv | st_reg.pat[c][i];
            end
         end
         st_next.err[c] = !st_reg.circ[c] && (|(bad_ord[c] & st_reg.en[c]));
         st_next.prev[c] = cnt_val[c];
         // each counter keeps its own pause state
         case (st_reg.pst[c])
            CMP_RUN:
            begin
               // status and pattern taken from one evaluation
               st_next.act[c] = live;
               st_next.cpat[c] = orv;
               // a fresh arrival on a limit starts the pause
               if ((|(at_lim[c] & st_reg.en[c])) && (cnt_val[c] != st_reg.prev[c]))
               begin
                  st_next.pst[c] = CMP_HOLD;
                  st_next.pcnt[c] = '0;
               end
            end
            CMP_HOLD:
            begin
               // frozen until the pause has run out
               st_next.pcnt[c] = st_reg.pcnt[c] + 1'b1;
               if (st_reg.pcnt[c] == PAUSE_LAST)
               begin
                  st_next.pst[c] = CMP_RUN;
               end
            end
            default: st_next.pst[c] = CMP_RUN;
         endcase
      end

      mode = st_reg.ctl[CRC_MODE_LO +: 8];
      sel = st_reg.ctl[CRC_SEL_LO +: 8];
      // comparison operation is not built here, so outputs stay off
      // no enabled range on either counter forces all off at once
      if ((mode != CRC_MODE_RANGE) || (st_reg.en[0] == 32'h0 && st_reg.en[1] == 32'h0))
      begin
         st_next.unit = 32'h0;
      end
      // AND skips counters with no enabled range
      else if (sel == CRC_SEL_AND)
      begin
         if (st_reg.en[0] == 32'h0)
         begin
            st_next.unit = st_reg.cpat[1];
         end
         else if (st_reg.en[1] == 32'h0)
         begin
            st_next.unit = st_reg.cpat[0];
         end
         else
         begin
            st_next.unit = st_reg.cpat[0] & st_reg.cpat[1];
         end
      end
      else
      begin
         st_next.unit = st_reg.cpat[0] | st_reg.cpat[1];
      end
      // low two pattern bits are the digital outputs
      st_next.dig0 = st_next.unit[0];
      st_next.dig1 = st_next.unit[1];
   end

   // the range memory resets too, so a stray enable never sees junk limits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.rdata;
   assign pready = st_reg.rdy;
   assign pslverr = st_reg.slverr;
   assign first_digital_output = st_reg.dig0;
   assign second_digital_output = st_reg.dig1;
   assign unit_output_pattern = st_reg.unit;
   // every bit is also an individual status line
   assign first_counter_active_ranges = st_reg.act[0];
   assign second_counter_active_ranges = st_reg.act[1];
   assign config_error = st_reg.err;

   // hysteresis is left out; limits act without a dead band

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_hold_two;
      st_reg.pst[0] == CMP_HOLD ##1 st_reg.pst[0] == CMP_HOLD;
   endsequence

   sequence s_hold_last;
      st_reg.pst[0] == CMP_HOLD && st_reg.pcnt[0] == PAUSE_LAST;
   endsequence

   a_hold_freeze: assert property (s_hold_two |-> $stable(st_reg.act[0]))
      else $error("active ranges changed during pause");
   a_hold_end: assert property (s_hold_last |=> st_reg.pst[0] == CMP_RUN)
      else $error("pause did not end after its length");
   a_other_runs: assert property ((st_reg.pst[0] == CMP_HOLD
      && st_reg.pst[1] == CMP_RUN)
      |=> st_reg.act[1] == ($past(in_rng[1]) & $past(st_reg.en[1])))
      else $error("second counter stalled by first counter pause");
   a_unit_or: assert property ((st_reg.ctl[CRC_MODE_LO +: 8] == CRC_MODE_RANGE
      && st_reg.ctl[CRC_SEL_LO +: 8] != CRC_SEL_AND
      && (st_reg.en[0] != 32'h0 || st_reg.en[1] != 32'h0))
      |=> unit_output_pattern == $past(st_reg.cpat[0] | st_reg.cpat[1]))
      else $error("unit pattern is not OR of counters");
   a_unit_and: assert property ((st_reg.ctl[CRC_MODE_LO +: 8] == CRC_MODE_RANGE
      && st_reg.ctl[CRC_SEL_LO +: 8] == CRC_SEL_AND && st_reg.en[0] != 32'h0
      && st_reg.en[1] != 32'h0)
      |=> unit_output_pattern == $past(st_reg.cpat[0] & st_reg.cpat[1]))
      else $error("unit pattern is not AND of counters");
   a_empty_off: assert property ((st_reg.en[0] == 32'h0
      && st_reg.en[1] == 32'h0)
      |=> unit_output_pattern == 32'h0)
      else $error("outputs on with no ranges enabled");
   a_digital_bits: assert property (first_digital_output == unit_output_pattern[0]
      && second_digital_output == unit_output_pattern[1])
      else $error("digital outputs differ from pattern bits");
   a_idle_nopat: assert property (st_reg.act[0] == 32'h0 |-> st_reg.cpat[0] == 32'h0)
      else $error("counter pattern set with no active range");
   a_disabled_off: assert property (st_reg.pst[0] == CMP_RUN
      |=> (st_reg.act[0] & ~$past(st_reg.en[0])) == 32'h0)
      else $error("disabled range reported active");
   a_lin_error: assert property ((!st_reg.circ[0]
      && (|(bad_ord[0] & st_reg.en[0])))
      |=> config_error[0])
      else $error("linear ordering error not flagged");
   a_apb_ready: assert property ((psel && !penable) |=> pready)
      else $error("apb access phase not answered");
endmodule : crc_top

// ---- dv/crc_host_model.sv ----
`timescale 1ns/1ps
module crc_host_model
(
   // apb clock
   input wire logic pclk,
   // apb request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   // apb answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end
   // no fixed latency assumed; only the bench timeout ends the wait
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data must not keep showing the last word
      pwdata <= ~d;
   endtask : xfer
endmodule : crc_host_model

// ---- dv/crc_top_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
   $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module crc_top_bench;
   import crc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, do1, do2;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, c1v, c2v, upat, act1, act2, q;
   logic [1:0] cerr;
   logic e;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   crc_top #(.PAUSE_CYCLES(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .first_counter_value(c1v), .second_counter_value(c2v),
      .first_digital_output(do1), .second_digital_output(do2),
      .unit_output_pattern(upat), .first_counter_active_ranges(act1),
      .second_counter_active_ranges(act2), .config_error(cerr));
   crc_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         conclude();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      host.xfer(1'b0, a, 32'h00000000, q, e);
   endtask : rd
   function automatic logic [11:0] ea(input logic c, input logic [4:0] n,
      input logic [1:0] w);
      ea = {2'b00, c, n, w, 2'b00};
   endfunction : ea
   task automatic went(input logic c, input logic [4:0] n, input logic [31:0] lo,
      input logic [31:0] up, input logic [31:0] pat);
      wr(ea(c, n, CRC_WRD_LOWER), lo);
      wr(ea(c, n, CRC_WRD_UPPER), up);
      wr(ea(c, n, CRC_WRD_PAT), pat);
   endtask : went
   task automatic t_regs();
      for (int i = 0; i < 8; i++)
      begin
         rd(CRC_OFF_OUT_CTL + 12'(4 * i));
         `CHK(q, 32'h00000000)
      end
      wr(CRC_OFF_ACT1, 32'hffffffff);
      rd(CRC_OFF_ACT1);
      `CHK(q, 32'h00000000)
      rd(12'h00c);
      `CHK(e, 1'b1)
      wr(ea(1'b1, 5'h1f, CRC_WRD_PAT), 32'ha5a5c3c3);
      rd(ea(1'b1, 5'h1f, CRC_WRD_PAT));
      `CHK(q, 32'ha5a5c3c3)
      `CHK(e, 1'b0)
   endtask : t_regs
   task automatic t_linear();
      went(1'b0, 5'h0, 32'hffffb1e0, 32'hffffd8f0, 32'h1);
      went(1'b0, 5'h1, 32'hfffffc18, 32'h00004a38, 32'ha);
      went(1'b0, 5'h2, 32'hffffec78, 32'h00002af8, 32'h4);
      went(1'b0, 5'h3, 32'h00001770, 32'h000061a8, 32'h9);
      wr(CRC_OFF_EN1, 32'h0000000b);
      c1v <= 32'h00003a98;
      wt(4);
      `CHK(act1, 32'h0000000a)
      `CHK(upat, 32'h0000000b)
      `CHK({do2, do1}, 2'b11)
      rd(CRC_OFF_ACT1);
      `CHK(q, 32'h0000000a)
      // range 2 holds the value but is disabled
      c1v <= 32'h00001388;
      wt(4);
      `CHK(upat, 32'h0000000a)
      `CHK({do2, do1}, 2'b10)
   endtask : t_linear
   task automatic t_circular();
      wr(CRC_OFF_CNT_TYPE, 32'h00000002);
      went(1'b1, 5'h0, 32'h02349340, 32'h00001770, 32'hc);
      went(1'b1, 5'h1, 32'h000186a0, 32'h000186a0, 32'h10);
      wr(CRC_OFF_EN2, 32'h00000003);
      c2v <= 32'h00000bb8;
      wt(4);
      `CHK(act2, 32'h00000001)
      c2v <= 32'h02625a00;
      wt(4);
      `CHK(act2, 32'h00000001)
      `CHK(upat, 32'h0000000e)
      `CHK(cerr, 2'b00)
      c2v <= 32'h000186a0;
      wt(15);
      `CHK(act2, 32'h00000002)
      c2v <= 32'h0000c350;
      wt(4);
      `CHK(act2, 32'h00000000)
   endtask : t_circular
   task automatic t_pause();
      // the limit value itself is still evaluated; the next value is not
      c1v <= 32'hffffd8f0;
      wt(1);
      c1v <= 32'h00003a98;
      c2v <= 32'h00000bb8;
      wt(4);
      `CHK(act1, 32'h00000001)
      `CHK(upat, 32'h0000000d)
      `CHK(act2, 32'h00000001)
      wt(12);
      `CHK(act1, 32'h0000000a)
      `CHK(upat, 32'h0000000f)
   endtask : t_pause
   task automatic t_combine();
      c1v <= 32'h00003a98;
      wr(CRC_OFF_OUT_CTL, 32'h00000100);
      wt(4);
      `CHK(upat, 32'h00000008)
      wr(CRC_OFF_EN2, 32'h00000000);
      wt(4);
      `CHK(upat, 32'h0000000b)
      wr(CRC_OFF_EN1, 32'h00000000);
      wt(4);
      `CHK(upat, 32'h00000000)
      wr(CRC_OFF_EN1, 32'h0000000b);
      wr(CRC_OFF_OUT_CTL, 32'h00000001);
      wt(4);
      `CHK(upat, 32'h00000000)
      wr(CRC_OFF_OUT_CTL, 32'h00000000);
      wt(4);
      rd(CRC_OFF_UNIT_PAT);
      `CHK(q, 32'h0000000b)
   endtask : t_combine
   task automatic t_cfgerr();
      went(1'b0, 5'h4, 32'h0000000a, 32'h00000005, 32'h20);
      wr(CRC_OFF_EN1, 32'h0000001b);
      wt(3);
      `CHK(cerr, 2'b01)
      rd(CRC_OFF_STATUS);
      `CHK(q[1:0], 2'b01)
      wr(ea(1'b0, 5'h4, CRC_WRD_UPPER), 32'h0000000a);
      wt(3);
      `CHK(cerr, 2'b00)
   endtask : t_cfgerr
   initial
   begin
      presetn = 1'b0;
      c1v = 32'h00000000;
      c2v = 32'h00000000;
      wt(5);
      presetn <= 1'b1;
      t_regs();
      t_linear();
      t_circular();
      t_pause();
      t_combine();
      t_cfgerr();
      conclude();
   end
endmodule : crc_top_bench
